// ===== ilpc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module ilpc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irq_accept,
  input  wire logic [3:0] delay,
  output logic            vector_ack
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_ack;
  // Fetch after a settable wait; slow fetches widen the offer window
  always_comb begin
    next_ack = irq_accept && !vector_ack && cnt >= delay;
    next_cnt = (irq_accept && !vector_ack && !next_ack) ? cnt + 4'h1 : 4'h0;
  end
  // State only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 4'h0;
      vector_ack <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      vector_ack <= next_ack;
    end
  end
endmodule
`default_nettype wire

// ===== ilpc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module ilpc_ctrl #(
  parameter int NUM_MASK = 22
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [7:0]       bus_rdata,
  input  wire logic [25:4] mask_req,
  input  wire logic        watchdog_irq,
  input  wire logic        software_trap_irq,
  input  wire logic        bad_opcode_irq,
  input  wire logic        watchdog_output_select,
  input  wire logic        vector_area_select,
  input  wire logic        serial_boot_mode,
  input  wire logic [43:0] priority_level_regs,
  input  wire logic        disable_instr,
  input  wire logic        enable_instr,
  input  wire logic        return_from_irq,
  output logic             irq_accept,
  output logic [15:0]      irq_vector,
  output logic [4:0]       irq_source,
  input  wire logic        vector_ack,
  output logic             master_accept_flag
);
  // ***********************************
  // State
  // ***********************************
  logic [25:3]                 pending_latch;
  logic [25:3]                 next_pending_latch;
  logic [25:4]                 source_accept_flag;
  logic [25:4]                 next_source_accept_flag;
  logic                        next_master_accept_flag;
  logic [7:0]                  saved_flags;
  logic [7:0]                  next_saved_flags;
  logic [2:0]                  nest_depth;
  logic [2:0]                  next_nest_depth;
  logic                        trap_hold;
  logic                        next_trap_hold;
  ilpc_pkg::ilpc_state_type    state;
  ilpc_pkg::ilpc_state_type    next_state;
  logic [15:0]                 next_irq_vector;
  logic [4:0]                  next_irq_source;
  logic [7:0]                  next_bus_rdata;
  logic                        pick_any;
  logic [4:0]                  pick_idx;
  logic [25:4]                 mask_ok;

  // ***********************************
  // Vector helper
  // ***********************************
  function automatic logic [15:0] vec_of(input logic [4:0] src, input logic low_area);
    logic [15:0] base;
    begin
      base = low_area ? ilpc_pkg::VEC_MASK_LOW : ilpc_pkg::VEC_MASK_TOP;
      if (src == 5'h00) vec_of = low_area ? ilpc_pkg::VEC_TRAP_LOW : ilpc_pkg::VEC_TRAP_TOP;
      else if (src == 5'(ilpc_pkg::WDT_BIT))
        vec_of = low_area ? ilpc_pkg::VEC_WDT_LOW : ilpc_pkg::VEC_WDT_TOP;
      else vec_of = base - {10'h000, 5'(src - 5'(ilpc_pkg::FIRST_MASK)), 1'b0};
    end
  endfunction

  // Read byte of a latch group; unused bits read zero
  function automatic logic [7:0] latch_byte(input logic [11:0] a, input logic [25:3] pl);
    begin
      unique case (a)
        ilpc_pkg::ADDR_LATCH_A: latch_byte = {pl[7:3], 3'h0};
        ilpc_pkg::ADDR_LATCH_B: latch_byte = pl[15:8];
        ilpc_pkg::ADDR_LATCH_C: latch_byte = pl[23:16];
        ilpc_pkg::ADDR_LATCH_D: latch_byte = {6'h00, pl[25:24]};
        default:                latch_byte = 8'h00;
      endcase
    end
  endfunction

  // ***********************************
  // Arbitration: enabled maskable pending
  // ***********************************
  assign mask_ok = pending_latch[25:4] & source_accept_flag
                   & {NUM_MASK{master_accept_flag}};

  // Level ties fall to lowest index, i.e. best basic priority
  ilpc_pick #(
    .N(NUM_MASK)
  ) u_pick (
    .req  (mask_ok),
    .level(priority_level_regs),
    .any  (pick_any),
    .index(pick_idx)
  );

  // ***********************************
  // Next-state logic
  // ***********************************
  always_comb begin
    next_pending_latch      = pending_latch;
    next_source_accept_flag = source_accept_flag;
    next_master_accept_flag = master_accept_flag;
    next_saved_flags        = saved_flags;
    next_nest_depth         = nest_depth;
    next_trap_hold          = trap_hold | software_trap_irq | bad_opcode_irq;
    next_state              = state;
    next_irq_vector         = irq_vector;
    next_irq_source         = irq_source;
    next_bus_rdata          = bus_rdata;
    // Software clears first so that hardware sets below win
    if (bus_wr) begin
      unique case (bus_addr)
        ilpc_pkg::ADDR_LATCH_A: next_pending_latch[7:4] = pending_latch[7:4] & bus_wdata[7:4];
        ilpc_pkg::ADDR_LATCH_B: next_pending_latch[15:8] = pending_latch[15:8] & bus_wdata;
        ilpc_pkg::ADDR_LATCH_C: next_pending_latch[23:16] = pending_latch[23:16] & bus_wdata;
        ilpc_pkg::ADDR_LATCH_D: next_pending_latch[25:24] = pending_latch[25:24] & bus_wdata[1:0];
        ilpc_pkg::ADDR_ACC_LOW: begin
          next_source_accept_flag[7:4] = bus_wdata[7:4];
          next_master_accept_flag      = bus_wdata[ilpc_pkg::MASTER_BIT];
        end
        ilpc_pkg::ADDR_ACC_HIGH: next_source_accept_flag[15:8]  = bus_wdata;
        ilpc_pkg::ADDR_ACC_EXT:  next_source_accept_flag[23:16] = bus_wdata;
        ilpc_pkg::ADDR_ACC_TOP:  next_source_accept_flag[25:24] = bus_wdata[1:0];
        default: ;
      endcase
    end
    // Watchdog bit untouched by writes
    if (bus_rd) begin
      if (bus_addr == ilpc_pkg::ADDR_ACC_LOW)
        next_bus_rdata = {source_accept_flag[7:4], 3'h0, master_accept_flag};
      else if (bus_addr == ilpc_pkg::ADDR_ACC_HIGH) next_bus_rdata = source_accept_flag[15:8];
      else if (bus_addr == ilpc_pkg::ADDR_ACC_EXT)  next_bus_rdata = source_accept_flag[23:16];
      else if (bus_addr == ilpc_pkg::ADDR_ACC_TOP)
        next_bus_rdata = {6'h00, source_accept_flag[25:24]};
      else next_bus_rdata = latch_byte(bus_addr, pending_latch);
    end
    if (disable_instr) next_master_accept_flag = 1'b0;
    if (enable_instr)  next_master_accept_flag = 1'b1;
    // Return pops the stacked master flag for nesting
    if (return_from_irq && nest_depth != 3'h0) begin
      next_master_accept_flag = saved_flags[0];
      next_saved_flags        = {1'b0, saved_flags[7:1]};
      next_nest_depth         = nest_depth - 3'h1;
    end
    unique case (state)
      ilpc_pkg::ILPC_IDLE, ilpc_pkg::ILPC_SVC: begin
        // Unmaskable first: shared trap slot, then watchdog
        if (trap_hold) begin
          next_state      = ilpc_pkg::ILPC_OFFER;
          next_irq_source = 5'h00;
          next_irq_vector = vec_of(5'h00, vector_area_select);
          next_trap_hold  = software_trap_irq | bad_opcode_irq;
        end else if (pending_latch[ilpc_pkg::WDT_BIT]) begin
          next_state      = ilpc_pkg::ILPC_OFFER;
          next_irq_source = 5'(ilpc_pkg::WDT_BIT);
          next_irq_vector = vec_of(5'(ilpc_pkg::WDT_BIT), vector_area_select);
          next_pending_latch[ilpc_pkg::WDT_BIT] = 1'b0;
        end else if (pick_any) begin
          next_state      = ilpc_pkg::ILPC_OFFER;
          next_irq_source = pick_idx + 5'(ilpc_pkg::FIRST_MASK);
          next_irq_vector = vec_of(pick_idx + 5'(ilpc_pkg::FIRST_MASK), vector_area_select);
          next_pending_latch[pick_idx + 5'(ilpc_pkg::FIRST_MASK)] = 1'b0;
        end
        if (next_state == ilpc_pkg::ILPC_OFFER) begin
          // Push on top of a return popped in this same cycle
          next_saved_flags        = {next_saved_flags[6:0], next_master_accept_flag};
          next_master_accept_flag = 1'b0;
          next_nest_depth         = (next_nest_depth == 3'h7) ? next_nest_depth
                                    : next_nest_depth + 3'h1;
        end
      end
      ilpc_pkg::ILPC_OFFER: begin
        if (vector_ack) next_state = ilpc_pkg::ILPC_SVC;
      end
      default: next_state = ilpc_pkg::ILPC_IDLE;
    endcase
    // Hardware set wins over any clear
    next_pending_latch[25:4] = next_pending_latch[25:4] | mask_req;
    if (watchdog_irq && !watchdog_output_select)
      next_pending_latch[ilpc_pkg::WDT_BIT] = 1'b1;
  end

  // ***********************************
  // Registers
  // ***********************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_latch      <= '0;
      source_accept_flag <= '0;
      master_accept_flag <= 1'b0;
      saved_flags        <= 8'h00;
      nest_depth         <= 3'h0;
      trap_hold          <= 1'b0;
      state              <= ilpc_pkg::ILPC_IDLE;
      irq_vector         <= ilpc_pkg::VEC_RESET;
      irq_source         <= 5'h00;
      bus_rdata          <= 8'h00;
    end else begin
      pending_latch      <= next_pending_latch;
      source_accept_flag <= next_source_accept_flag;
      master_accept_flag <= next_master_accept_flag;
      saved_flags        <= next_saved_flags;
      nest_depth         <= next_nest_depth;
      trap_hold          <= next_trap_hold;
      state              <= next_state;
      irq_vector         <= next_irq_vector;
      irq_source         <= next_irq_source;
      bus_rdata          <= next_bus_rdata;
    end
  end

  // Accept stands while vector is offered; in serial boot mode boot option vectors are never offered
  assign irq_accept = (state == ilpc_pkg::ILPC_OFFER) && !(serial_boot_mode &&
                      (irq_vector == ilpc_pkg::VEC_OPT_LO ||
                       irq_vector == ilpc_pkg::VEC_OPT_HI));
endmodule
`default_nettype wire

// ===== ilpc_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ilpc_ctrl_bench;
  logic        clk, rst_n, bus_wr, bus_rd, wdi, trap, bad, wsel, vsel, di, ei, ret;
  logic        acc, ack, mflag;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata;
  logic [25:4] mreq;
  logic [43:0] plr;
  logic [15:0] vec;
  logic [4:0]  src;
  logic [3:0]  dly;
  int          errors, n_compared;
  always #25 clk = ~clk;
  ilpc_ctrl DUT (.clk, .rst_n, .bus_addr(addr), .bus_wdata(wdata), .bus_wr, .bus_rd,
    .bus_rdata(rdata), .mask_req(mreq), .watchdog_irq(wdi), .software_trap_irq(trap),
    .bad_opcode_irq(bad), .watchdog_output_select(wsel), .vector_area_select(vsel),
    .serial_boot_mode(1'b0), .priority_level_regs(plr), .disable_instr(di),
    .enable_instr(ei), .return_from_irq(ret), .irq_accept(acc), .irq_vector(vec),
    .irq_source(src), .vector_ack(ack), .master_accept_flag(mflag));
  ilpc_cpu_model CPU (.clk, .rst_n, .irq_accept(acc), .delay(dly), .vector_ack(ack));
  // ************************************
  // Shared drivers and checks
  // ************************************
  task tick; @(posedge clk); #5; endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(ref logic s); s = 1'b1; tick; s = 1'b0; endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    bus_wr = 1'b1;
    tick;
    bus_wr = 1'b0;
    tick; // Idle edge keeps back-to-back strobes apart
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task rdc(input logic [11:0] a, input logic [7:0] e);
    addr = a;
    bus_rd = 1'b1;
    tick;
    bus_rd = 1'b0;
    chk("register read", {8'h00, e}, {8'h00, rdata});
    tick;
  endtask
  function automatic logic [15:0] mv(input int s);
    return (vsel ? 16'h01F6 : 16'hFFF6) - 16'(2 * (s - 4));
  endfunction
  // Bounded wait for an offer, judge it, then wait for the fetch to end it
  task wait_acc(input logic [15:0] v, input logic [4:0] s);
    int i;
    for (i = 0; i < 20 && acc !== 1'b1; i++) tick;
    chk("irq_vector", v, vec);
    if (s != 5'h1F) chk("irq_source", {11'h000, s}, {11'h000, src});
    chk("master flag", 16'h0000, {15'h0000, mflag});
    for (i = 0; i < 20 && acc === 1'b1; i++) tick;
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task t_latch;
    for (int a = 0; a < 4; a++) rdc(12'hFE0 + 12'(a), 8'h00);
    rdc(12'h03A, 8'h00);
    rdc(12'h100, 8'h00);
    pulse(wdi);
    mreq = '1;
    tick;
    mreq = '0;
    rdc(12'hFE0, 8'hF0);
    rdc(12'hFE3, 8'h03);
    wr(12'hFE1, 8'hFF);
    rdc(12'hFE1, 8'hFF);
    wr(12'hFE1, 8'hA5);
    rdc(12'hFE1, 8'hA5);
    for (int a = 0; a < 4; a++) wr(12'hFE0 + 12'(a), 8'h00);
    rdc(12'hFE2, 8'h00);
  endtask
  task t_vec;
    wr(12'h03B, 8'hFF);
    wr(12'h03C, 8'hFF);
    wr(12'h03D, 8'h03);
    wr(12'h03A, 8'hF1);
    for (int s = 4; s < 26; s++) begin
      vsel = s[0];
      dly = s[0] ? 4'h6 : 4'h0;
      mreq[s] = 1'b1;
      tick;
      mreq = '0;
      wait_acc(mv(s), 5'(s));
      pulse(ret);
      chk("restored flag", 16'h0001, {15'h0000, mflag});
    end
    rdc(12'hFE1, 8'h00);
    vsel = 1'b0;
  endtask
  task t_pri(input logic [43:0] lvl, input int first, input int second);
    pulse(di);
    plr = lvl;
    mreq[6] = 1'b1;
    mreq[9] = 1'b1;
    tick;
    mreq = '0;
    pulse(ei);
    wait_acc(mv(first), 5'(first));
    repeat (5) tick;
    chk("offer before enable", 16'h0000, {15'h0000, acc});
    pulse(ei);
    wait_acc(mv(second), 5'(second));
    pulse(ret);
    tick;
    pulse(ret);
  endtask
  task t_nmi;
    pulse(di);
    wsel = 1'b0;
    dly = 4'h8;
    trap = 1'b1;
    wdi = 1'b1;
    tick;
    trap = 1'b0;
    wdi = 1'b0;
    wr(12'hFE0, 8'h00);
    rdc(12'hFE0, 8'h08);
    wait_acc(16'hFFFC, 5'h00);
    pulse(ret);
    wait_acc(16'hFFF8, 5'h03);
    pulse(ret);
    vsel = 1'b1;
    dly = 4'h0;
    pulse(bad);
    wait_acc(16'h01FC, 5'h00);
    pulse(ret);
  endtask
  task t_gate;
    wr(12'h03A, 8'h01);
    mreq[5] = 1'b1;
    tick;
    mreq = '0;
    repeat (5) tick;
    chk("masked offer", 16'h0000, {15'h0000, acc});
    rdc(12'hFE0, 8'h20);
  endtask
  task complete_run;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {clk, rst_n, bus_wr, bus_rd, wdi, trap, bad, di, ei, ret} = '0;
    {wsel, vsel, addr, wdata, mreq, plr, dly} = '0;
    wsel = 1'b1;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    #5 rst_n = 1'b1;
    tick;
    t_latch;
    t_vec;
    t_pri(44'h0, 6, 9);
    t_pri(44'hC00, 9, 6);
    t_nmi;
    t_gate;
    complete_run;
  end
  // Hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    #2000000;
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire

// ===== ilpc_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ilpc_ctrl_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        vector_area_select,
  input wire logic        irq_accept,
  input wire logic [15:0] irq_vector,
  input wire logic [4:0]  irq_source,
  input wire logic        vector_ack,
  input wire logic        master_accept_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ************************************
  // Offer, vectors, flag and latch read padding
  // ************************************
  AST_HOLD: assert property (irq_accept && !vector_ack |=> irq_accept && $stable(irq_vector))
    else $error("vector offer moved before fetch");
  AST_DROP: assert property (irq_accept && vector_ack |=> !irq_accept)
    else $error("offer kept after fetch");
  AST_FLAG: assert property ($rose(irq_accept) |-> !master_accept_flag)
    else $error("master flag not cleared on accept");
  AST_GATE: assert property ($rose(irq_accept) && irq_source >= 5'h04 |-> $past(master_accept_flag))
    else $error("maskable taken with master flag low");
  AST_MVEC: assert property (irq_accept && irq_source >= 5'h04 |-> irq_vector ==
    (vector_area_select ? 16'h01F6 : 16'hFFF6) - {10'h000, irq_source - 5'h04, 1'b0})
    else $error("maskable vector wrong");
  AST_TVEC: assert property (irq_accept && irq_source == 5'h00 |-> irq_vector ==
    (vector_area_select ? 16'h01FC : 16'hFFFC)) else $error("trap vector wrong");
  AST_WVEC: assert property (irq_accept && irq_source == 5'h03 |-> irq_vector ==
    (vector_area_select ? 16'h01F8 : 16'hFFF8)) else $error("watchdog vector wrong");
  AST_RST: assert property ($rose(rst_n) |-> !irq_accept && irq_vector == 16'hFFFE)
    else $error("idle state wrong after reset");
  AST_RDPAD: assert property (bus_rd && bus_addr == 12'hFE3 |=> bus_rdata[7:2] == 6'h00)
    else $error("unused latch bits read nonzero");
  cover property ($rose(irq_accept) && irq_source == 5'h00);
  cover property (vector_ack && vector_area_select);
  cover property (irq_accept && irq_source == 5'h19);
endmodule
bind ilpc_ctrl ilpc_ctrl_checker u_chk (.clk, .rst_n, .bus_addr, .bus_rd, .bus_rdata,
  .vector_area_select, .irq_accept, .irq_vector, .irq_source, .vector_ack, .master_accept_flag);
`default_nettype wire

// ===== ilpc_pick.sv
`timescale 1ns/1ns
`default_nettype none
module ilpc_pick #(
  parameter int N = 22
) (
  input  wire logic [N-1:0]   req,
  input  wire logic [2*N-1:0] level,
  output logic                any,
  output logic [4:0]          index
);
  // ***********************************
  // Highest level wins, lower index breaks ties
  // ***********************************
  logic [1:0] best;
  always_comb begin
    any   = 1'b0;
    index = 5'h00;
    best  = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin // Reverse scan keeps lowest index on tie
      if (req[i] && (!any || level[2*i +: 2] >= best)) begin
        any   = 1'b1;
        index = 5'(i);
        best  = level[2*i +: 2];
      end
    end
  end
endmodule
`default_nettype wire

// ===== ilpc_pkg.sv
package ilpc_pkg;
  // ***********************************
  // Register map
  // ***********************************
  localparam logic [11:0] ADDR_LATCH_A  = 12'hFE0;
  localparam logic [11:0] ADDR_LATCH_B  = 12'hFE1;
  localparam logic [11:0] ADDR_LATCH_C  = 12'hFE2;
  localparam logic [11:0] ADDR_LATCH_D  = 12'hFE3;
  localparam logic [11:0] ADDR_ACC_LOW  = 12'h03A;
  localparam logic [11:0] ADDR_ACC_HIGH = 12'h03B;
  localparam logic [11:0] ADDR_ACC_EXT  = 12'h03C;
  localparam logic [11:0] ADDR_ACC_TOP  = 12'h03D;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam int          MASTER_BIT    = 0;
  // ***********************************
  // Sources
  // ***********************************
  localparam int          NUM_SOURCES   = 25;
  localparam int          LATCH_LO      = 3;
  localparam int          LATCH_HI      = 25;
  localparam int          WDT_BIT       = 3;
  localparam int          FIRST_MASK    = 4;
  // ***********************************
  // Vectors
  // ***********************************
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP_TOP  = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP_LOW  = 16'h01FC;
  localparam logic [15:0] VEC_WDT_TOP   = 16'hFFF8;
  localparam logic [15:0] VEC_WDT_LOW   = 16'h01F8;
  localparam logic [15:0] VEC_MASK_TOP  = 16'hFFF6;
  localparam logic [15:0] VEC_MASK_LOW  = 16'h01F6;
  localparam logic [15:0] VEC_OPT_LO    = 16'hFFFA;
  localparam logic [15:0] VEC_OPT_HI    = 16'hFFFB;
  localparam logic [4:0]  BASIC_RESET   = 5'h01;
  localparam logic [4:0]  BASIC_NMI     = 5'h02;
  localparam logic [4:0]  BASIC_FIRST   = 5'h05;
  localparam logic [4:0]  BASIC_LAST    = 5'h1A;
  localparam int          LEVEL_BITS    = 2;
  typedef enum logic [2:0] {
    ILPC_IDLE  = 3'b001,
    ILPC_OFFER = 3'b010,
    ILPC_SVC   = 3'b100
  } ilpc_state_type;
endpackage
